// file: hw/config_memory_error_detect.v
// Notes on behaviour
// - In user mode all frames are read one after another for checking.
// - A found soft error raises the error output pin.
// - Load-time check always runs; user-mode checking only when enabled.
// - Each frame ends in its own 32-bit check word.
// - Column check-bits sit in per-column registers covering all frames.
// - Column engines run in parallel, count set by frame length.
// - Each column engine folds 128 bits per frame in four cycles.
// - A pass ends only after every frame has been read.
// - Frame check words made while loading; column bits after configuration.
// - First user-mode pass checks frames against their own check words.
// - Column bits computed only after the first frame-based pass.
// - Column bits recomputed after reconfiguration and after protocol sessions.
// - Error message register rewritten on each detected error.
// - Error message register is 78 bits: type, location, syndrome.
// - Location is frame, dword and bit; zero for uncorrectable errors.
// - Fabric update register loads one cycle after message is valid.
// - Fabric update register has a hold enable protecting reads.
// - Fabric logic reads through the fabric shift register.
// - JTAG update register loads one cycle after message is valid.
// - JTAG update register has a hold enable protecting reads.
// - JTAG host shifts out after loading the error shift instruction.
// - Message fields follow the fixed order and widths.
// - Error pin stays high until the message is readable.
// - Error during column update sets flag, pin high until reconfiguration.
`default_nettype none

module config_memory_error_detect
#(
	parameter NUM_FRAMES   = 64,
	parameter FRAME_DWORDS = 16
)
(
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire        i_cfg_loading,
	input  wire        i_cfg_wr_valid,
	input  wire [31:0] i_cfg_wr_data,
	output reg         o_cfg_check_wr,
	output reg  [31:0] o_cfg_check_word,
	input  wire        i_user_mode,
	input  wire        i_check_enable,
	input  wire        i_session_done,
	output reg         o_rd_en,
	output reg  [15:0] o_rd_frame,
	output reg  [9:0]  o_rd_dword,
	input  wire        i_rd_valid,
	input  wire [31:0] i_rd_data,
	output reg         o_crc_error,
	output reg         o_scan_active,
	input  wire        i_user_hold,
	input  wire        i_user_shift_en,
	input  wire        i_user_shift,
	output wire        o_user_dout,
	input  wire        i_jtag_hold,
	input  wire        i_shift_out_error_instr,
	input  wire        i_jtag_shift_dr,
	input  wire        i_jtag_shift,
	output wire        o_jtag_dout
);

`include "config_memory_error_detect_regs.vh"

	localparam NCOL = FRAME_DWORDS / `SLICE_DWORDS;
	localparam BW   = $clog2(FRAME_DWORDS * 32);
	localparam [BW-1:0]  D_LAST  = FRAME_DWORDS * 32 - 1;
	localparam [9:0]     NW      = FRAME_DWORDS;
	localparam [9:0]     NW_LAST = FRAME_DWORDS - 1;
	localparam [15:0]    F_LAST  = NUM_FRAMES - 1;
	localparam [2:0] S_IDLE = 3'h0, S_READ = 3'h1, S_DRAIN = 3'h2, S_SEARCH = 3'h3;
	localparam [2:0] S_REPORT = 3'h4, S_PASS = 3'h5, S_COLCHK = 3'h6;
	localparam [1:0] P_VERIFY = 2'h0, P_UPDATE = 2'h1, P_CHECK = 2'h2;

	// Same fold as the column engines
	function [31:0] fold_dw;
		input [31:0] crc;
		input [31:0] d;
		integer i;
		reg [31:0] c;
		reg        fb;
		begin
			c = crc;
			for (i = 31; i >= 0; i = i - 1)
			begin
				fb = c[31] ^ d[i];
				c  = {c[30:0], 1'b0} ^ (fb ? `CHK_POLY : 32'h00000000);
			end
			fold_dw = c;
		end
	endfunction

	reg [2:0]        state_r;
	reg [1:0]        pass_r;
	reg [9:0]        rx_dw_r;
	reg [31:0]       crc_r;
	reg [31:0]       syn_r;
	reg [31:0]       t_r;
	reg [BW-1:0]     d_r;
	reg [2:0]        ftype_r;
	reg [2:0]        ctype_r;
	reg [BW-1:0]     loc_r;
	reg              frame_err_pass_r;
	reg              need_upd_r;
	reg              upd_err_r;
	reg              cfg_err_r;
	reg [9:0]        cfg_dw_r;
	reg [31:0]       cfg_crc_r;
	reg              cfg_load_d_r;
	reg [`MSG_W-1:0] msg_r;
	reg              msg_valid_r;
	reg              msg_valid_d_r;
	reg              pass_end_r;

	wire        run_ok    = i_user_mode & i_check_enable & ~i_cfg_loading;
	wire        cfg_start = i_cfg_loading & ~cfg_load_d_r;
	wire        clr       = i_rst | cfg_start;
	wire        rx_data   = i_rd_valid & (rx_dw_r < NW);
	wire        rx_chk    = i_rd_valid & (rx_dw_r == NW);
	wire [31:0] t_nxt     = {t_r[30:0], 1'b0} ^ (t_r[31] ? `CHK_POLY : 32'h00000000);
	wire [9:0]  d_hi      = {{(10 - (BW - 5)){1'b0}}, loc_r[BW-1:5]};
	wire [9:0]  loc_dw    = NW_LAST - d_hi;
	wire [NCOL-1:0] col_mis;

	// ----------------------------------------------------------------
	// Load-time frame check words and stream check
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys)
	begin
		cfg_load_d_r <= i_rst ? 1'b0 : i_cfg_loading;
		if (i_rst)
		begin
			cfg_dw_r         <= 10'h000;
			cfg_crc_r        <= `CHK_RESET;
			cfg_err_r        <= 1'b0;
			o_cfg_check_wr   <= 1'b0;
			o_cfg_check_word <= `CHK_RESET;
		end
		else
		begin
			o_cfg_check_wr <= 1'b0;
			if (cfg_start)
			begin
				cfg_dw_r  <= 10'h000;
				cfg_crc_r <= `CHK_RESET;
				cfg_err_r <= 1'b0;
			end
			else if (i_cfg_loading && i_cfg_wr_valid)
			begin
				if (cfg_dw_r == NW)
				begin
					// frame check word made on chip
					o_cfg_check_wr   <= 1'b1;
					o_cfg_check_word <= cfg_crc_r;
					if (cfg_crc_r != i_cfg_wr_data)
						cfg_err_r <= 1'b1;
					cfg_dw_r  <= 10'h000;
					cfg_crc_r <= `CHK_RESET;
				end
				else
				begin
					cfg_dw_r  <= cfg_dw_r + 10'h001;
					cfg_crc_r <= fold_dw(cfg_crc_r, i_cfg_wr_data);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Scan, locate and report
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys)
	begin
		if (clr)
		begin
			state_r <= S_IDLE; pass_r <= P_VERIFY; rx_dw_r <= 10'h000;
			crc_r <= `CHK_RESET; syn_r <= `CHK_RESET; t_r <= `CHK_RESET;
			d_r <= {BW{1'b0}}; loc_r <= {BW{1'b0}};
			ftype_r <= `ERR_NONE; ctype_r <= `ERR_NONE;
			frame_err_pass_r <= 1'b0; need_upd_r <= 1'b0; upd_err_r <= 1'b0;
			msg_r <= `MSG_RESET; msg_valid_r <= 1'b0; pass_end_r <= 1'b0;
			o_rd_en <= 1'b0; o_rd_frame <= 16'h0000; o_rd_dword <= 10'h000;
			o_crc_error <= 1'b0; o_scan_active <= 1'b0;
		end
		else
		begin
			o_rd_en     <= 1'b0;
			msg_valid_r <= 1'b0;
			pass_end_r  <= 1'b0;
			// a finished protocol session asks for recompute
			if (i_session_done)
				need_upd_r <= 1'b1;
			// pin falls once update registers hold the message
			if (msg_valid_d_r)
				o_crc_error <= upd_err_r;
			o_scan_active <= (state_r != S_IDLE);
			// data dwords fold, the last word is the stored check word
			if (rx_data)
			begin
				crc_r   <= fold_dw(crc_r, i_rd_data);
				rx_dw_r <= rx_dw_r + 10'h001;
			end
			case (state_r)
			S_IDLE:
			begin
				o_crc_error <= upd_err_r | cfg_err_r;
				// start reading once in user mode with checking on
				if (run_ok)
				begin
					state_r    <= S_READ;
					o_rd_frame <= 16'h0000;
					o_rd_dword <= 10'h000;
					rx_dw_r    <= 10'h000;
					crc_r      <= `CHK_RESET;
				end
			end
			S_READ:
			begin
				o_rd_en <= 1'b1;
				if (o_rd_en)
					o_rd_dword <= o_rd_dword + 10'h001;
				if (o_rd_en && o_rd_dword == NW - 10'h001)
					state_r <= S_DRAIN;
			end
			S_DRAIN:
			begin
				if (rx_chk)
				begin
					syn_r   <= crc_r ^ i_rd_data;
					rx_dw_r <= 10'h000;
					crc_r   <= `CHK_RESET;
					if (crc_r != i_rd_data)
					begin
						o_crc_error      <= 1'b1;
						frame_err_pass_r <= 1'b1;
						t_r     <= `CHK_POLY;
						d_r     <= {BW{1'b0}};
						state_r <= S_SEARCH;
					end
					else if (o_rd_frame == F_LAST)
						state_r <= S_PASS;
					else
					begin
						o_rd_frame <= o_rd_frame + 16'h0001;
						o_rd_dword <= 10'h000;
						state_r    <= S_READ;
					end
				end
			end
			S_SEARCH:
			begin
				// Walk single and adjacent-pair syndromes; slow but tiny
				loc_r   <= d_r;
				state_r <= S_REPORT;
				if (syn_r == t_r)
					ftype_r <= `ERR_SINGLE;
				else if (syn_r == (t_r ^ t_nxt) && d_r != D_LAST)
					ftype_r <= `ERR_DOUBLE;
				else if (d_r == D_LAST)
					ftype_r <= `ERR_UNCORR;
				else
				begin
					state_r <= S_SEARCH;
					t_r     <= t_nxt;
					d_r     <= d_r + {{(BW-1){1'b0}}, 1'b1};
				end
				ctype_r <= `ERR_NONE;
			end
			S_REPORT:
			begin
				// rewrite the message on every detection
				msg_valid_r <= 1'b1;
				// type, location and syndrome in 78 bits
				msg_r <= {o_rd_frame, loc_dw[1:0], loc_r[4:0],
					(ftype_r == `ERR_NONE) ? ctype_r : ftype_r,
					syn_r, loc_dw, loc_r[4:0], ftype_r, 1'b0,
					upd_err_r | (pass_r == P_UPDATE)};
				if (ftype_r == `ERR_UNCORR || ftype_r == `ERR_NONE)
				begin
					msg_r[`MSG_FRAME_LSB+15:`MSG_COLTYPE_LSB+3] <= 23'h000000;
					msg_r[`MSG_FDW_LSB+9:`MSG_FTYPE_LSB+3]      <= 15'h0000;
				end
				// error during column update sticks until reconfig
				if (pass_r == P_UPDATE)
					upd_err_r <= 1'b1;
				if (ftype_r == `ERR_NONE)
				begin
					pass_end_r <= 1'b1;
					state_r    <= S_COLCHK;
				end
				else if (o_rd_frame == F_LAST)
					state_r <= S_PASS;
				else
				begin
					o_rd_frame <= o_rd_frame + 16'h0001;
					o_rd_dword <= 10'h000;
					state_r    <= S_READ;
				end
			end
			S_PASS:
			begin
				pass_end_r <= 1'b1;
				state_r    <= S_COLCHK;
			end
			S_COLCHK:
			begin
				ftype_r          <= `ERR_NONE;
				if (pass_r == P_CHECK && |col_mis && !frame_err_pass_r && !pass_end_r)
				begin
					// Column mismatch no frame could place
					o_crc_error      <= 1'b1;
					ctype_r          <= `ERR_UNCORR;
					syn_r            <= `CHK_RESET;
					frame_err_pass_r <= 1'b1;
					state_r          <= S_REPORT;
				end
				else if (!pass_end_r)
				begin
					// Cleared only on leaving, so a located error masks the column miss
					frame_err_pass_r <= 1'b0;
					// column bits only after the first frame pass
					if (pass_r == P_VERIFY || need_upd_r)
					begin
						pass_r     <= P_UPDATE;
						need_upd_r <= i_session_done;
					end
					else
						pass_r <= P_CHECK;
					o_rd_frame <= 16'h0000;
					o_rd_dword <= 10'h000;
					state_r    <= run_ok ? S_READ : S_IDLE;
				end
			end
			default:
				state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Column engines and message unload ports
	// ----------------------------------------------------------------
	wire [1:0] hold_v  = {i_jtag_hold, i_user_hold};
	// JTAG shifts only under the error shift instruction
	wire [1:0] shen_v  = {i_shift_out_error_instr & i_jtag_shift_dr, i_user_shift_en};
	wire [1:0] step_v  = {i_jtag_shift, i_user_shift};
	wire [1:0] dout_v;

	always @(posedge i_clk_sys)
		msg_valid_d_r <= clr ? 1'b0 : msg_valid_r;

	genvar g;
	generate
		for (g = 0; g < NCOL; g = g + 1)
		begin : g_col
			localparam [7:0] CIDX = g;
			col_check_engine u_eng
			(
				.i_clk_sys  (i_clk_sys),
				.i_rst      (clr),
				.i_dw_valid (rx_data && rx_dw_r[9:`SLICE_SHIFT] == CIDX && pass_r != P_VERIFY),
				.i_dw_data  (i_rd_data),
				.i_pass_end (pass_end_r && pass_r != P_VERIFY),
				.i_store    (pass_r == P_UPDATE),
				.o_mismatch (col_mis[g])
			);
		end
		for (g = 0; g < 2; g = g + 1)
		begin : g_port
			reg [`MSG_W-1:0] upd_r;
			reg [`MSG_W-1:0] sh_r;
			always @(posedge i_clk_sys)
			begin
				if (i_rst)
				begin
					upd_r <= `MSG_RESET;
					sh_r  <= `MSG_RESET;
				end
				else
				begin
					// fabric copy one cycle after valid
					// JTAG copy one cycle after valid
					// hold enable freezes the fabric copy
					// hold enable freezes the JTAG copy
					if (msg_valid_r && !hold_v[g])
						upd_r <= msg_r;
					// readers see only the shift register
					if (!shen_v[g])
						sh_r <= upd_r;
					else if (step_v[g])
						sh_r <= {1'b0, sh_r[`MSG_W-1:1]}; // LSB first
				end
			end
			assign dout_v[g] = sh_r[0];
		end
	endgenerate

	assign o_user_dout = dout_v[0];
	assign o_jtag_dout = dout_v[1];

endmodule // config_memory_error_detect

`default_nettype wire

// file: include/config_memory_error_detect_regs.vh
`ifndef CONFIG_MEMORY_ERROR_DETECT_REGS_VH
`define CONFIG_MEMORY_ERROR_DETECT_REGS_VH

// ----------------------------------------------------------------
// Error message register layout (bit positions, LSB of each field)
// ----------------------------------------------------------------
`define MSG_W            78
`define MSG_FRAME_LSB    62
`define MSG_FRAME_W      16
`define MSG_COLDW_LSB    60
`define MSG_COLDW_W      2
`define MSG_COLBIT_LSB   55
`define MSG_COLBIT_W     5
`define MSG_COLTYPE_LSB  52
`define MSG_TYPE_W       3
`define MSG_SYN_LSB      20
`define MSG_SYN_W        32
`define MSG_FDW_LSB      10
`define MSG_FDW_W        10
`define MSG_FBIT_LSB     5
`define MSG_FBIT_W       5
`define MSG_FTYPE_LSB    2
`define MSG_RSVD_BIT     1
`define MSG_UPDERR_BIT   0
`define MSG_RESET        78'h0

// ----------------------------------------------------------------
// Error type codes
// ----------------------------------------------------------------
`define ERR_NONE         3'h0
`define ERR_SINGLE       3'h1
`define ERR_DOUBLE       3'h2
`define ERR_UNCORR       3'h7

// ----------------------------------------------------------------
// Check-bit code and scan geometry
// ----------------------------------------------------------------
`define CHK_W            32
`define CHK_POLY         32'h04C11DB7
`define CHK_RESET        32'h0
`define SLICE_DWORDS     4
`define SLICE_SHIFT      2

`endif

// file: hw/col_check_engine.v
`default_nettype none

// ----------------------------------------------------------------
// One column engine: folds the 128-bit slice of every frame
// ----------------------------------------------------------------
module col_check_engine
(
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire        i_dw_valid,
	input  wire [31:0] i_dw_data,
	input  wire        i_pass_end,
	input  wire        i_store,
	output wire        o_mismatch
);

`include "config_memory_error_detect_regs.vh"

	reg [31:0] acc_r;
	reg [31:0] chk_r;
	reg        mismatch_r;

	// Serial MSB-first fold of one dword, zero initial value
	function [31:0] fold_dw;
		input [31:0] crc;
		input [31:0] d;
		integer i;
		reg [31:0] c;
		reg        fb;
		begin
			c = crc;
			for (i = 31; i >= 0; i = i - 1)
			begin
				fb = c[31] ^ d[i];
				c  = {c[30:0], 1'b0} ^ (fb ? `CHK_POLY : 32'h00000000);
			end
			fold_dw = c;
		end
	endfunction

	// ----------------------------------------------------------------
	// Accumulate, then store or compare at the end of a pass
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			acc_r      <= `CHK_RESET;
			chk_r      <= `CHK_RESET;
			mismatch_r <= 1'b0;
		end
		else if (i_pass_end)
		begin
			acc_r <= `CHK_RESET;
			if (i_store)
			begin
				chk_r      <= acc_r;
				mismatch_r <= 1'b0;
			end
			else
				mismatch_r <= (acc_r != chk_r);
		end
		else if (i_dw_valid)
			acc_r <= fold_dw(acc_r, i_dw_data); // Four cycles cover 128 bits
	end

	assign o_mismatch = mismatch_r;

endmodule // col_check_engine

`default_nettype wire

// file: tb/emr_checker_properties.sv
`default_nettype none
// ------------------------------
// Port checker for error detect
// ------------------------------
module msg_checker #(parameter NUM_FRAMES = 64, parameter FRAME_DWORDS = 16)
(
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	input wire logic       i_cfg_loading,
	input wire logic       i_cfg_wr_valid,
	input wire logic       i_user_mode,
	input wire logic       i_check_enable,
	input wire logic       o_cfg_check_wr,
	input wire logic       o_rd_en,
	input wire logic [15:0] o_rd_frame,
	input wire logic [9:0] o_rd_dword,
	input wire logic       o_crc_error,
	input wire logic       i_user_shift_en,
	input wire logic       i_user_shift,
	input wire logic       o_user_dout,
	input wire logic       i_shift_out_error_instr,
	input wire logic       i_jtag_shift_dr,
	input wire logic       i_jtag_shift,
	input wire logic       o_jtag_dout
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Scan may run only in enabled user mode
	wire logic run_ok = i_user_mode & i_check_enable & ~i_cfg_loading;
	wire logic jt_en = i_shift_out_error_instr & i_jtag_shift_dr;
	read_gated_a: assert property (o_rd_en |-> $past(run_ok)) else $error("read while off");
	read_range_a: assert property (o_rd_en |-> o_rd_dword <= FRAME_DWORDS && o_rd_frame < NUM_FRAMES) else $error("read out of range");
	frame_start_a: assert property ($rose(o_rd_en) |-> o_rd_dword == 0) else $error("frame not from start");
	dword_step_a: assert property (o_rd_en && o_rd_dword < FRAME_DWORDS && run_ok |=> o_rd_en && o_rd_dword == $past(o_rd_dword) + 1 && $stable(o_rd_frame)) else $error("dword skipped");
	frame_gap_a: assert property (o_rd_en && o_rd_dword == FRAME_DWORDS |=> !o_rd_en) else $error("no wait for check");
	check_pulse_a: assert property (o_cfg_check_wr |-> $past(i_cfg_loading && i_cfg_wr_valid) ##1 !o_cfg_check_wr) else $error("bad check pulse");
	reset_quiet_a: assert property ($past(i_rst) |-> !o_crc_error && !o_rd_en && !o_cfg_check_wr) else $error("active after reset");
	user_hold_a: assert property ((i_user_shift_en && !i_user_shift) [*2] |=> $stable(o_user_dout)) else $error("user shift moved");
	jtag_hold_a: assert property ((jt_en && !i_jtag_shift) [*2] |=> $stable(o_jtag_dout)) else $error("jtag shift moved");
	cover property ($rose(o_crc_error));
	cover property (o_cfg_check_wr);
	cover property (i_user_shift_en && i_user_shift);
	cover property (jt_en && i_jtag_shift);
endmodule // msg_checker

bind config_memory_error_detect msg_checker
	#(.NUM_FRAMES(NUM_FRAMES), .FRAME_DWORDS(FRAME_DWORDS)) chk_u
(
	.i_clk_sys, .i_rst, .i_cfg_loading, .i_cfg_wr_valid, .i_user_mode, .i_check_enable,
	.o_cfg_check_wr, .o_rd_en, .o_rd_frame, .o_rd_dword, .o_crc_error, .i_user_shift_en,
	.i_user_shift, .o_user_dout, .i_shift_out_error_instr, .i_jtag_shift_dr, .i_jtag_shift,
	.o_jtag_dout
);
`default_nettype wire

// file: tb/cfg_mem_model.sv
`default_nettype none
// ------------------------------
// Read-back memory model
// ------------------------------
module cfg_mem_model #(parameter NF = 4, parameter ND = 4)
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_req,
	input  wire logic [15:0] i_frame,
	input  wire logic [9:0]  i_dword,
	input  wire logic [3:0]  i_lat,
	output var  logic        o_valid,
	output var  logic [31:0] o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [NF][ND+1];
	logic [31:0] flip [NF][ND+1];
	logic [31:0] q_dat [$];
	int          q_due [$];
	int          cyc;
	// Clean memory, no upsets yet
	initial
	begin
		foreach (flip[a, b]) flip[a][b] = 32'h0;
		o_data = 32'h0;
	end
	// In-order answers; idle data toggles so stale words never look valid
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (i_rst)
		begin
			q_dat.delete();
			q_due.delete();
			o_valid <= 1'b0;
		end
		else
		begin
			if (i_req)
			begin
				q_dat.push_back(mem[i_frame][i_dword] ^ flip[i_frame][i_dword]);
				q_due.push_back(cyc + i_lat);
			end
			if (q_due.size() > 0 && q_due[0] <= cyc)
			begin
				o_valid <= 1'b1;
				o_data <= q_dat.pop_front();
				void'(q_due.pop_front());
			end
			else
			begin
				o_valid <= 1'b0;
				o_data <= ~o_data;
			end
		end
	end
endmodule // cfg_mem_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`include "config_memory_error_detect_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam NF = 4;
	localparam ND = 4;
	logic clk, rst, ld, wv, um, en, sd, u_hold, u_en, u_sh, j_hold, j_ir, j_dr, j_sh;
	logic [31:0] wd;
	logic [3:0] lat;
	wire logic cw, re, rv, err, ud, jo, act;
	wire logic [31:0] cwd, rdat;
	wire logic [15:0] rf;
	wire logic [9:0] rdw;
	int seed = 38, fail_count = 0, cmp_count = 0, reads = 0, n, f, d, b;
	int seen [NF];
	logic [31:0] fd [NF][ND+1];
	logic [77:0] got, e1, e2, m1, m2;

	config_memory_error_detect #(.NUM_FRAMES(NF), .FRAME_DWORDS(ND)) dut_u (.i_clk_sys(clk),
		.i_rst(rst), .i_cfg_loading(ld), .i_cfg_wr_valid(wv), .i_cfg_wr_data(wd),
		.o_cfg_check_wr(cw), .o_cfg_check_word(cwd), .i_user_mode(um), .i_check_enable(en),
		.i_session_done(sd), .o_rd_en(re), .o_rd_frame(rf), .o_rd_dword(rdw), .i_rd_valid(rv),
		.i_rd_data(rdat), .o_crc_error(err), .o_scan_active(act), .i_user_hold(u_hold),
		.i_user_shift_en(u_en), .i_user_shift(u_sh), .o_user_dout(ud), .i_jtag_hold(j_hold),
		.i_shift_out_error_instr(j_ir), .i_jtag_shift_dr(j_dr), .i_jtag_shift(j_sh),
		.o_jtag_dout(jo));
	cfg_mem_model #(.NF(NF), .ND(ND)) mdl_u (.i_clk(clk), .i_rst(rst), .i_req(re),
		.i_frame(rf), .i_dword(rdw), .i_lat(lat), .o_valid(rv), .o_data(rdat));

	// ------------------------------
	// Reference model and tasks
	// ------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Tally check-word reads per frame
	always @(posedge clk)
	begin
		if (re === 1'b1) reads++;
		if (re === 1'b1 && rdw == ND) seen[rf]++;
	end
	function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] x);
		for (int k = 31; k >= 0; k--) c = {c[30:0], 1'b0} ^ ((c[31] ^ x[k]) ? `CHK_POLY : 32'h0);
		return c;
	endfunction
	function automatic logic [77:0] mk(int fr, int dw, int bt, logic [31:0] m, logic [2:0] t);
		logic [31:0] c;
		logic [77:0] e;
		c = 32'h0;
		for (int k = 0; k < ND; k++) c = fold(c, fd[fr][k] ^ ((k == dw) ? m : 32'h0));
		e = 78'h0;
		e[77:62] = fr[15:0];
		e[51:20] = c ^ fd[fr][ND];
		e[19:10] = dw[9:0];
		e[9:5] = bt[4:0];
		e[4:2] = t;
		return e;
	endfunction
	task tick(int k);
		repeat (k) @(posedge clk);
	endtask
	task close_out();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Bounded wait for the error pin level
	task wait_pin(logic v);
		n = 0;
		while (err !== v && n < 3000) begin @(negedge clk); n++; end
		if (n >= 3000) begin fail_count++; close_out(); end
	endtask
	// Load stream: data words, then the frame's own check word
	task load_all();
		logic [31:0] c;
		ld <= 1'b1;
		tick(2);
		for (int fr = 0; fr < NF; fr++)
		begin
			c = 32'h0;
			for (int k = 0; k <= ND; k++)
			begin
				fd[fr][k] = (k < ND) ? $random(seed) : c;
				if (k < ND) c = fold(c, fd[fr][k]);
				mdl_u.mem[fr][k] = fd[fr][k];
				wv <= 1'b1;
				wd <= fd[fr][k];
				tick(1);
			end
			wv <= 1'b0;
			n = 0;
			while (cw !== 1'b1 && n < 5) begin @(negedge clk); n++; end
			`CHK(cw, 1'b1)
			`CHK(cwd, c)
			tick(1);
		end
		ld <= 1'b0;
		tick(2);
	endtask
	// Serial unload, low bit first, one shift pulse per bit
	task shift_out(logic jt, output logic [77:0] v);
		if (jt) begin j_ir <= 1'b1; j_dr <= 1'b1; end else u_en <= 1'b1;
		tick(2);
		for (int i = 0; i < `MSG_W; i++)
		begin
			@(negedge clk);
			v[i] = jt ? jo : ud;
			@(posedge clk);
			if (jt) j_sh <= 1'b1; else u_sh <= 1'b1;
			tick(1);
			j_sh <= 1'b0;
			u_sh <= 1'b0;
			tick(1);
		end
		j_ir <= 1'b0;
		j_dr <= 1'b0;
		u_en <= 1'b0;
		tick(1);
	endtask
	// Upset one frame until the pin rises, then wait for the message
	task inject(int fr, int dw, logic [31:0] m);
		mdl_u.flip[fr][dw] = m;
		wait_pin(1'b1);
		mdl_u.flip[fr][dw] = 32'h0;
		wait_pin(1'b0);
		tick(3);
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		{rst, ld, wv, um, en, sd, u_hold, u_en, u_sh, j_hold, j_ir, j_dr, j_sh} = 13'h1000;
		wd = 32'h0;
		lat = 4'h0;
		m1 = {16'hFFFF, 10'h0, 52'hF_FFFF_FFFF_FFFF};
		m2 = {16'hFFFF, 10'h0, 32'hFFFF_FFFF, 15'h0, 5'h1B};
		tick(12);
		rst <= 1'b0;
		tick(2);
		`CHK(err, 1'b0)
		load_all();
		um <= 1'b1;
		tick(100);
		`CHK(reads, 0)
		`CHK(act, 1'b0)
		$display("test idle done");
		en <= 1'b1;
		lat <= 4'($unsigned($random(seed)) % 4);
		tick(600);
		for (int fr = 0; fr < NF; fr++) `CHK(seen[fr] >= 3, 1'b1)
		`CHK(err, 1'b0)
		`CHK(act, 1'b1)
		$display("test scan done");
		f = $unsigned($random(seed)) % NF;
		d = $unsigned($random(seed)) % ND;
		b = $unsigned($random(seed)) % 31;
		e1 = mk(f, d, b, 32'h1 << b, `ERR_SINGLE);
		inject(f, d, 32'h1 << b);
		shift_out(1'b0, got);
		`CHK(got & m1, e1 & m1)
		shift_out(1'b1, got);
		`CHK(got & m1, e1 & m1)
		$display("test single done");
		u_hold <= 1'b1;
		f = $unsigned($random(seed)) % NF;
		d = $unsigned($random(seed)) % ND;
		e2 = mk(f, d, 0, 32'h3 << b, `ERR_DOUBLE);
		inject(f, d, 32'h3 << b);
		shift_out(1'b1, got);
		`CHK(got & m2, e2 & m2)
		shift_out(1'b0, got);
		`CHK(got & m1, e1 & m1)
		u_hold <= 1'b0;
		j_hold <= 1'b1;
		$display("test hold done");
		mdl_u.flip[1][1] = 32'h10;
		sd <= 1'b1;
		tick(1);
		sd <= 1'b0;
		tick(1500);
		n = 0;
		repeat (300) begin @(negedge clk); if (err === 1'b1) n++; end
		`CHK(n, 300)
		// JTAG copy frozen since the hold test, fabric copy follows
		shift_out(1'b1, got);
		`CHK(got & m2, e2 & m2)
		e1 = mk(1, 1, 4, 32'h10, `ERR_SINGLE) | 78'h1;
		shift_out(1'b0, got);
		`CHK(got & m1, e1 & m1)
		j_hold <= 1'b0;
		mdl_u.flip[1][1] = 32'h0;
		load_all();
		tick(600);
		`CHK(err, 1'b0)
		$display("test update done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
